// ### pkg/bzs_pkg.sv
// Purpose: shared constants and helpers for the bipolar transcoder
// Assumes: line symbols travel as {pos,neg} pairs
// Notes:   pattern slots count from the oldest symbol of a zero run
package bzs_pkg;
  // Substitution coding, one active at a time
  typedef enum logic [1:0] {
    CODE_EIGHT = 2'h0,
    CODE_SIX   = 2'h1,
    CODE_FOUR  = 2'h2
  } code_e;

  // Symbol codes {pos,neg}
  localparam logic [1:0] SYM_ZERO  = 2'h0;
  localparam logic [1:0] SYM_MINUS = 2'h1;
  localparam logic [1:0] SYM_PLUS  = 2'h2;
  // Encoder only: plain mark, polarity picked when sent
  localparam logic [1:0] SYM_MARK  = 2'h3;

  // Delay line length and zero-run lengths
  localparam int unsigned LINE_LEN  = 8;
  localparam logic [3:0]  RUN_EIGHT = 4'h8;
  localparam logic [3:0]  RUN_SIX   = 4'h6;
  localparam logic [3:0]  RUN_FOUR  = 4'h4;

  // Pulse slots inside each pattern
  localparam logic [2:0] S8_A = 3'h3;
  localparam logic [2:0] S8_B = 3'h4;
  localparam logic [2:0] S8_C = 3'h6;
  localparam logic [2:0] S8_D = 3'h7;
  localparam logic [2:0] S6_A = 3'h1;
  localparam logic [2:0] S6_B = 3'h2;
  localparam logic [2:0] S6_C = 3'h4;
  localparam logic [2:0] S6_D = 3'h5;
  localparam logic [2:0] S4_B = 3'h0;
  localparam logic [2:0] S4_V = 3'h3;

  // Input buffer shape
  localparam int unsigned FIFO_WIDTH = 1;
  localparam int unsigned FIFO_DEPTH = 16;

  // Zero-run length of a coding
  function automatic logic [3:0] run_len(input code_e c);
    case (c)
      CODE_SIX:  run_len = RUN_SIX;
      CODE_FOUR: run_len = RUN_FOUR;
      default:   run_len = RUN_EIGHT;
    endcase
  endfunction

  // Pulse of a given sign
  function automatic logic [1:0] polar(input logic s_pos);
    polar = s_pos ? SYM_PLUS : SYM_MINUS;
  endfunction

  // Symbol k of the pattern; s_pos is the preceding mark, bform picks B00V
  function automatic logic [1:0] pat_sym(input code_e c, input logic [2:0] k,
                                         input logic s_pos, input logic bform);
    logic [1:0] sp;
    logic [1:0] sn;
    sp = polar(s_pos);
    sn = polar(!s_pos);
    pat_sym = SYM_ZERO;
    case (c)
      CODE_SIX:
        pat_sym = (k == S6_A || k == S6_D) ? sp : (k == S6_B || k == S6_C) ? sn : SYM_ZERO;
      CODE_FOUR:
        pat_sym = (k == S4_V) ? (bform ? sn : sp) : (k == S4_B && bform) ? sn : SYM_ZERO;
      default:
        pat_sym = (k == S8_A || k == S8_D) ? sp : (k == S8_B || k == S8_C) ? sn : SYM_ZERO;
    endcase
  endfunction
endpackage

// ### logic/bzs_transcoder.sv
// Purpose: bipolar zero-substitution encoder and decoder, three codings
// Assumes: one clock, CLK_EN high marks every active cycle
// Notes:   encoder sends one symbol per bit popped from its input FIFO
`timescale 1ns/100ps
`default_nettype none

// Input buffer: flop storage, power-of-two depth
module bzs_fifo
  import bzs_pkg::*;
#(
  parameter int unsigned WIDTH = FIFO_WIDTH,
  parameter int unsigned DEPTH = FIFO_DEPTH
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             en,
  input  wire logic             clr,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = AW + 1;

  logic [DEPTH-1:0][WIDTH-1:0] mem_reg, mem_next;   // Storage
  logic [AW-1:0]               wr_reg, wr_next;     // Write index
  logic [AW-1:0]               rd_reg, rd_next;     // Read index
  logic [CW-1:0]               cnt_reg, cnt_next;   // Fill level
  logic                        rdy_reg, rdy_next;   // Not full
  logic                        push;
  logic                        pop;

  assign in_ready  = rdy_reg;
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];

  // Next pointers and level; full is kept as a flop so ready is clean
  always_comb
  begin
    push     = en & in_valid & rdy_reg;
    pop      = en & out_ready & out_valid;
    mem_next = mem_reg;
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (clr && en)
    begin
      // Flush drops anything queued
      wr_next  = '0;
      rd_next  = '0;
      cnt_next = '0;
    end
    else
    begin
      if (push)
      begin
        mem_next[wr_reg] = in_data;
        wr_next          = AW'(wr_reg + 1'b1);
      end
      if (pop)
        rd_next = AW'(rd_reg + 1'b1);
      cnt_next = CW'(cnt_reg + CW'(push) - CW'(pop));
    end
    rdy_next = (cnt_next != CW'(DEPTH));
  end

  // Registers only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_reg <= '0;
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b1;
    end
    else
    begin
      mem_reg <= mem_next;
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
      rdy_reg <= rdy_next;
    end
  end
endmodule

// Behaviour
// R1: ones alternate polarity, zeros send no pulse
// R2: violation means two same-polarity marks in a row
// R3: eight-zero mode substitutes every run of eight
// R4: eight-zero patterns 000+-0-+ and 000-+0+-
// R5: eight-zero violations at slots four and seven
// R6: six-zero mode substitutes every run of six
// R7: six-zero patterns 0+-0-+ and 0-+0+-
// R8: six-zero violations at slots two and five
// R9: four-zero mode ends pattern with a violation
// R10: odd mark count gives 000V, even B00V
// R11: 000V violation repeats last mark polarity
// R12: B00V pulses equal, opposite the last mark
// R13: three codings selectable, exactly one active
// R14: decoder restores zeros and pulses pattern flag
// R15: decoder flags violations outside valid patterns
// R16: error when both line inputs high together
// R17: delay line holds bits until run known
// R18: track last mark and parity after substitution
// R19: master clear empties counters, lines and flags
module bzs_transcoder
  import bzs_pkg::*;
(
  input  wire logic       SYS_CLK,
  input  wire logic       RSTN,
  input  wire logic       CLK_EN,
  input  wire logic       GLOBAL_CLEAR,
  input  wire logic [1:0] CODE_SEL,
  input  wire logic       NRZ_SERIAL_IN,
  input  wire logic       NRZ_VALID,
  output var  logic       NRZ_READY,
  input  wire logic       LINE_READY,
  output var  logic       POS_LINE_OUT,
  output var  logic       NEG_LINE_OUT,
  output var  logic       LINE_STROBE,
  input  wire logic       POS_LINE_IN,
  input  wire logic       NEG_LINE_IN,
  output var  logic       NRZ_SERIAL_OUT,
  output var  logic       LINE_VIOLATION_FLAG,
  output var  logic       SUBSTITUTION_SEEN_FLAG,
  output var  logic       LINE_ERROR_FLAG
);
  // Pin synchronisers: {pos,neg}, coding select, clear
  logic [1:0] rx_s1_reg, rx_s1_next, rx_s2_reg, rx_s2_next;
  logic [1:0] sel_s1_reg, sel_s1_next, sel_s2_reg, sel_s2_next;
  logic       clr_s1_reg, clr_s1_next, clr_s2_reg, clr_s2_next;
  code_e      mode;          // Active coding
  logic [3:0] rl;            // Run length of active coding
  logic       clr;           // Synchronised master clear

  // Input buffer hookup
  logic       fifo_vld;      // A bit waits
  logic       fifo_bit;      // Oldest bit
  logic       adv;           // Encoder sends a symbol this cycle

  // Encoder state
  logic [LINE_LEN-1:0][1:0] enc_line_reg, enc_line_next;  // Pending symbols
  logic [3:0] zcnt_reg, zcnt_next;     // Zeros seen in a row
  logic       last_reg, last_next;     // Last mark was positive
  logic       par_reg, par_next;       // Odd marks sent since reset or clear
  logic       pos_reg, pos_next;
  logic       neg_reg, neg_next;
  logic       stb_reg, stb_next;
  logic [1:0] etap;                    // Symbol leaving the line
  logic [1:0] send;                    // Resolved symbol
  logic       pol_after;
  logic       par_after;

  // Decoder state: slot = {exempt,pos,neg}
  logic [LINE_LEN-1:0][2:0] dec_line_reg, dec_line_next;
  logic [LINE_LEN-1:0][2:0] win;       // Line after shifting in
  logic       dlast_reg, dlast_next;   // Last received mark positive
  logic       dseen_reg, dseen_next;   // A mark has been received
  logic       nrz_reg, nrz_next;
  logic       viol_reg, viol_next;
  logic       seen_reg, seen_next;
  logic       err_reg, err_next;
  logic [2:0] dtap;
  logic       dnz;
  logic       dpol_after;
  logic       rx_err;
  logic       hit0;
  logic       hit1;

  // R13 one coding from the select; unused code falls back to eight
  assign mode = (sel_s2_reg == 2'h3) ? CODE_EIGHT : code_e'(sel_s2_reg);
  assign rl   = run_len(mode);
  assign clr  = clr_s2_reg;
  assign adv  = CLK_EN & fifo_vld & LINE_READY;

  assign POS_LINE_OUT           = pos_reg;
  assign NEG_LINE_OUT           = neg_reg;
  assign LINE_STROBE            = stb_reg;
  assign NRZ_SERIAL_OUT         = nrz_reg;
  assign LINE_VIOLATION_FLAG    = viol_reg;
  assign SUBSTITUTION_SEEN_FLAG = seen_reg;
  assign LINE_ERROR_FLAG        = err_reg;

  // Buffer between producer and encoder; line driver stall fills it
  bzs_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (SYS_CLK),
    .rst_n     (RSTN),
    .en        (CLK_EN),
    .clr       (clr),
    .in_valid  (NRZ_VALID),
    .in_ready  (NRZ_READY),
    .in_data   (NRZ_SERIAL_IN),
    .out_valid (fifo_vld),
    .out_ready (LINE_READY),
    .out_data  (fifo_bit)
  );

  // Synchroniser shifting, frozen with the enable
  always_comb
  begin
    rx_s1_next  = CLK_EN ? {POS_LINE_IN, NEG_LINE_IN} : rx_s1_reg;
    rx_s2_next  = CLK_EN ? rx_s1_reg : rx_s2_reg;
    sel_s1_next = CLK_EN ? CODE_SEL : sel_s1_reg;
    sel_s2_next = CLK_EN ? sel_s1_reg : sel_s2_reg;
    clr_s1_next = CLK_EN ? GLOBAL_CLEAR : clr_s1_reg;
    clr_s2_next = CLK_EN ? clr_s1_reg : clr_s2_reg;
  end

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rx_s1_reg  <= 2'h0;
      rx_s2_reg  <= 2'h0;
      sel_s1_reg <= 2'h0;
      sel_s2_reg <= 2'h0;
      clr_s1_reg <= 1'b0;
      clr_s2_reg <= 1'b0;
    end
    else
    begin
      rx_s1_reg  <= rx_s1_next;
      rx_s2_reg  <= rx_s2_next;
      sel_s1_reg <= sel_s1_next;
      sel_s2_reg <= sel_s2_next;
      clr_s1_reg <= clr_s1_next;
      clr_s2_reg <= clr_s2_next;
    end
  end

  // Encoder: the line is exactly one run long, so when the last zero of a
  // run arrives every earlier symbol has left and polarity is settled
  always_comb
  begin
    enc_line_next = enc_line_reg;
    zcnt_next     = zcnt_reg;
    last_next     = last_reg;
    par_next      = par_reg;
    pos_next      = pos_reg;
    neg_next      = neg_reg;
    stb_next      = 1'b0;
    // R17 tap at run length delays each bit
    etap          = enc_line_reg[3'(rl - 4'h1)];
    // R1 plain mark takes the opposite polarity
    send          = (etap == SYM_MARK) ? polar(!last_reg) : etap;
    // R18 polarity and parity follow what is sent
    pol_after     = (send == SYM_ZERO) ? last_reg : (send == SYM_PLUS);
    par_after     = par_reg ^ (send != SYM_ZERO);
    if (!CLK_EN)
      stb_next = stb_reg;
    else if (clr)
    begin
      // R19 clear delay line, counter, polarity, parity
      enc_line_next = '0;
      zcnt_next     = 4'h0;
      last_next     = 1'b0;
      par_next      = 1'b0;
      pos_next      = 1'b0;
      neg_next      = 1'b0;
    end
    else if (adv)
    begin
      {pos_next, neg_next} = send;
      stb_next      = 1'b1;
      last_next     = pol_after;
      par_next      = par_after;
      enc_line_next = {enc_line_reg[LINE_LEN-2:0], fifo_bit ? SYM_MARK : SYM_ZERO};
      if (fifo_bit)
        zcnt_next = 4'h0;
      else if (zcnt_reg == rl - 4'h1)
      begin
        // R3 R6 R9 full run replaced by its pattern
        zcnt_next = 4'h0;
        for (int k = 0; k < LINE_LEN; k++)
        begin
          // R4 R5 R7 R8 R10 R11 R12 pattern by mode, polarity, parity
          if (4'(k) < rl)
            enc_line_next[3'(rl - 4'(k) - 4'h1)] = pat_sym(mode, 3'(k), pol_after, !par_after);
        end
      end
      else
        zcnt_next = 4'(zcnt_reg + 4'h1);
    end
  end

  // Encoder registers; reset leaves last mark negative so first goes positive
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      enc_line_reg <= '0;
      zcnt_reg     <= 4'h0;
      last_reg     <= 1'b0;
      par_reg      <= 1'b0;
      pos_reg      <= 1'b0;
      neg_reg      <= 1'b0;
      stb_reg      <= 1'b0;
    end
    else
    begin
      enc_line_reg <= enc_line_next;
      zcnt_reg     <= zcnt_next;
      last_reg     <= last_next;
      par_reg      <= par_next;
      pos_reg      <= pos_next;
      neg_reg      <= neg_next;
      stb_reg      <= stb_next;
    end
  end

  // Decoder: one received symbol per enabled cycle; patterns are matched on
  // the shifted window and marked exempt so they read as zeros
  always_comb
  begin
    dec_line_next = dec_line_reg;
    dlast_next    = dlast_reg;
    dseen_next    = dseen_reg;
    nrz_next      = nrz_reg;
    viol_next     = viol_reg;
    seen_next     = seen_reg;
    err_next      = err_reg;
    // R16 both lines high is an error, taken as no pulse
    rx_err        = &rx_s2_reg;
    dtap          = dec_line_reg[3'(rl - 4'h1)];
    dnz           = (dtap[1:0] != SYM_ZERO);
    dpol_after    = dnz ? (dtap[1:0] == SYM_PLUS) : dlast_reg;
    win           = {dec_line_reg[LINE_LEN-2:0], {1'b0, rx_err ? SYM_ZERO : rx_s2_reg}};
    hit0          = 1'b1;
    hit1          = 1'b1;
    for (int k = 0; k < LINE_LEN; k++)
    begin
      // R14 compare window with both pattern forms
      if (4'(k) < rl)
      begin
        if (win[3'(rl - 4'(k) - 4'h1)] != {1'b0, pat_sym(mode, 3'(k), dpol_after, 1'b0)})
          hit0 = 1'b0;
        if (win[3'(rl - 4'(k) - 4'h1)] != {1'b0, pat_sym(mode, 3'(k), dpol_after, 1'b1)})
          hit1 = 1'b0;
      end
    end
    if (CLK_EN && clr)
    begin
      // R19 clear decoder line, polarity and flags
      dec_line_next = '0;
      dlast_next    = 1'b0;
      dseen_next    = 1'b0;
      nrz_next      = 1'b0;
      viol_next     = 1'b0;
      seen_next     = 1'b0;
      err_next      = 1'b0;
    end
    else if (CLK_EN)
    begin
      dec_line_next = win;
      if (hit0 | hit1)
      begin
        for (int k = 0; k < LINE_LEN; k++)
        begin
          if (4'(k) < rl)
            dec_line_next[3'(rl - 4'(k) - 4'h1)][2] = 1'b1;
        end
      end
      // R14 exempt slots come out as zeros
      nrz_next   = dnz & !dtap[2];
      // R2 R15 same polarity twice outside a pattern
      viol_next  = dnz & !dtap[2] & dseen_reg & ((dtap[1:0] == SYM_PLUS) == dlast_reg);
      seen_next  = hit0 | hit1;
      err_next   = rx_err;
      dlast_next = dpol_after;
      dseen_next = dseen_reg | dnz;
    end
  end

  // Decoder registers
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      dec_line_reg <= '0;
      dlast_reg    <= 1'b0;
      dseen_reg    <= 1'b0;
      nrz_reg      <= 1'b0;
      viol_reg     <= 1'b0;
      seen_reg     <= 1'b0;
      err_reg      <= 1'b0;
    end
    else
    begin
      dec_line_reg <= dec_line_next;
      dlast_reg    <= dlast_next;
      dseen_reg    <= dseen_next;
      nrz_reg      <= nrz_next;
      viol_reg     <= viol_next;
      seen_reg     <= seen_next;
      err_reg      <= err_next;
    end
  end
endmodule

`default_nettype wire

// ### tb/bzs_transcoder_sva.sv
// Purpose: port assertions for the bipolar transcoder
// Assumes: CLK_EN stays high while checked
// Notes:   age counters gate the clear and error windows
`timescale 1ns/100ps
`default_nettype none
module bzs_transcoder_chk
(
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic CLK_EN,
  input wire logic GLOBAL_CLEAR,
  input wire logic NRZ_READY,
  input wire logic LINE_READY,
  input wire logic POS_LINE_OUT,
  input wire logic NEG_LINE_OUT,
  input wire logic LINE_STROBE,
  input wire logic POS_LINE_IN,
  input wire logic NEG_LINE_IN,
  input wire logic NRZ_SERIAL_OUT,
  input wire logic LINE_VIOLATION_FLAG,
  input wire logic SUBSTITUTION_SEEN_FLAG,
  input wire logic LINE_ERROR_FLAG
);
  logic [3:0] clr_age_reg, clr_age_next; // Cycles since clear pin
  logic [3:0] err_age_reg, err_age_next; // Cycles since both inputs high
  // Ages saturate so quiet spells never wrap
  always_comb
  begin
    clr_age_next = GLOBAL_CLEAR ? 4'h0 : clr_age_reg + 4'(clr_age_reg != 4'hF);
    err_age_next = (POS_LINE_IN && NEG_LINE_IN) ? 4'h0 : err_age_reg + 4'(err_age_reg != 4'hF);
  end
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      clr_age_reg <= 4'hF;
      err_age_reg <= 4'hF;
    end
    else
    begin
      clr_age_reg <= clr_age_next;
      err_age_reg <= err_age_next;
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  sequence s_clear_held; GLOBAL_CLEAR [*6]; endsequence
  sequence s_zero_out; !NRZ_SERIAL_OUT [*3]; endsequence
  property p_strobe_cause; LINE_STROBE |-> $past(LINE_READY && CLK_EN); endproperty
  a_strobe_cause: assert property (p_strobe_cause)
    else $error("strobe without ready");
  property p_out_legal; !(POS_LINE_OUT && NEG_LINE_OUT); endproperty
  a_out_legal: assert property (p_out_legal)
    else $error("both line outputs high");
  property p_hold; (!LINE_STROBE && clr_age_reg > 4'h5) |-> $stable({POS_LINE_OUT, NEG_LINE_OUT}); endproperty
  a_hold: assert property (p_hold)
    else $error("symbol changed without strobe");
  property p_err_cause; LINE_ERROR_FLAG |-> err_age_reg <= 4'hC; endproperty
  a_err_cause: assert property (p_err_cause)
    else $error("error flag without cause");
  property p_err_answer; (POS_LINE_IN && NEG_LINE_IN && clr_age_reg == 4'hF) |-> ##[3:12] LINE_ERROR_FLAG;
  endproperty
  a_err_answer: assert property (p_err_answer)
    else $error("error flag missing");
  property p_clear; s_clear_held |-> !SUBSTITUTION_SEEN_FLAG && !LINE_VIOLATION_FLAG && NRZ_READY; endproperty
  a_clear: assert property (p_clear)
    else $error("clear left state behind");
  property p_sub_zero; SUBSTITUTION_SEEN_FLAG |-> ##2 s_zero_out; endproperty
  a_sub_zero: assert property (p_sub_zero)
    else $error("pattern not restored as zeros");
  property p_sub_pulse; SUBSTITUTION_SEEN_FLAG |=> !SUBSTITUTION_SEEN_FLAG; endproperty
  a_sub_pulse: assert property (p_sub_pulse)
    else $error("pattern flag too long");
endmodule
bind bzs_transcoder bzs_transcoder_chk i_bzs_transcoder_chk (.SYS_CLK, .RSTN, .CLK_EN, .GLOBAL_CLEAR,
  .NRZ_READY, .LINE_READY, .POS_LINE_OUT, .NEG_LINE_OUT, .LINE_STROBE, .POS_LINE_IN, .NEG_LINE_IN,
  .NRZ_SERIAL_OUT, .LINE_VIOLATION_FLAG, .SUBSTITUTION_SEEN_FLAG, .LINE_ERROR_FLAG);
`default_nettype wire

// ### tb/bzs_line_partner.sv
// Purpose: bipolar line driver and receiver stand-in
// Assumes: one symbol taken per strobe
// Notes:   idle line sits at zero level, as a real pair does
`timescale 1ns/100ps
`default_nettype none
module bzs_line_partner
(
  input  wire logic clk,
  input  wire logic hold,       // Stall the encoder
  input  wire logic loop,       // Echo taken symbols to the decoder
  input  wire logic pos_out,
  input  wire logic neg_out,
  input  wire logic strobe,
  output var  logic line_ready,
  output var  logic pos_in,
  output var  logic neg_in
);
  logic [1:0] rx_q[$]; // Symbols taken from the encoder
  logic [1:0] tx_q[$]; // Symbols still to drive
  assign line_ready = !hold;
  initial {pos_in, neg_in} = 2'h0;
  // Take a symbol mid-cycle, where the strobe has settled; echo in the same
  // step so the returned stream stays gapless or patterns break
  always @(negedge clk)
  begin
    if (strobe === 1'b1)
    begin
      rx_q.push_back({pos_out, neg_out});
      if (loop)
        tx_q.push_back({pos_out, neg_out});
    end
    {pos_in, neg_in} <= (tx_q.size() != 0) ? tx_q.pop_front() : 2'h0;
  end
endmodule
`default_nettype wire

// ### tb/bzs_transcoder_tb.sv
// Purpose: self-checking bench for the bipolar transcoder
// Assumes: CLK_EN dropped only in the buffer test; partner echoes symbols back
// Notes:   expected symbols come from a local reference coder
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("BAD t=%0t %0h %0h", $time, g, e); end end
module bzs_transcoder_tb
  import bzs_pkg::*;
;
  logic sys_clk = 1'b0, rstn = 1'b0, clr = 1'b0, din = 1'b0, dval = 1'b0, hold = 1'b0, loop = 1'b1, cen = 1'b1;
  logic [1:0] sel = 2'h0;
  logic ready, lrdy, pos_o, neg_o, stb, pos_i, neg_i, nrz_o, viol, subst, err;
  int n_fail = 0, total_checks = 0, n_sub, n_vio, n_err, n_one, exp_sub;
  logic bits[$];       // Bits to send
  logic [1:0] exp_q[$]; // Symbols expected on the line
  always #2 sys_clk = !sys_clk;
  // Pulse tallies for decoder checks, taken mid-cycle where outputs have settled
  always @(negedge sys_clk)
  begin
    n_sub += (subst === 1'b1);
    n_vio += (viol === 1'b1);
    n_err += (err === 1'b1);
    n_one += (nrz_o === 1'b1);
  end
  bzs_transcoder i_bzs_transcoder (.SYS_CLK(sys_clk), .RSTN(rstn), .CLK_EN(cen), .GLOBAL_CLEAR(clr),
    .CODE_SEL(sel), .NRZ_SERIAL_IN(din), .NRZ_VALID(dval), .NRZ_READY(ready), .LINE_READY(lrdy),
    .POS_LINE_OUT(pos_o), .NEG_LINE_OUT(neg_o), .LINE_STROBE(stb), .POS_LINE_IN(pos_i),
    .NEG_LINE_IN(neg_i), .NRZ_SERIAL_OUT(nrz_o), .LINE_VIOLATION_FLAG(viol),
    .SUBSTITUTION_SEEN_FLAG(subst), .LINE_ERROR_FLAG(err));
  bzs_line_partner i_bzs_line_partner (.clk(sys_clk), .hold(hold), .loop(loop), .pos_out(pos_o),
    .neg_out(neg_o), .strobe(stb), .line_ready(lrdy), .pos_in(pos_i), .neg_in(neg_i));
  task automatic end_of_test();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Reference coder; last mark starts negative
  function automatic void ref_code(input int c);
    int rl, zc, par;
    logic pol;
    logic [1:0] p, m;
    string pat;
    rl = (c == 1) ? 6 : (c == 2) ? 4 : 8;
    zc = 0;
    par = 0;
    pol = 1'b0;
    exp_sub = 0;
    exp_q = {};
    repeat (rl) exp_q.push_back(SYM_ZERO);
    foreach (bits[i])
    begin
      p = pol ? SYM_PLUS : SYM_MINUS;
      m = pol ? SYM_MINUS : SYM_PLUS;
      zc = bits[i] ? 0 : zc + 1;
      par += bits[i];
      pol ^= bits[i];
      exp_q.push_back(bits[i] ? m : SYM_ZERO);
      if (zc == rl)
      begin
        pat = (c == 1) ? "0pm0mp" : (c != 2) ? "000pm0mp" : par[0] ? "000p" : "m00m";
        foreach (pat[k])
          exp_q[exp_q.size() - rl + k] = (pat[k] == "p") ? p : (pat[k] == "m") ? m : SYM_ZERO;
        pol ^= (pat[0] == "m");
        zc = 0;
        par = 0;
        exp_sub++;
      end
    end
  endfunction
  // Clear, select coding, settle
  task automatic set_mode(input logic [1:0] c);
    @(negedge sys_clk);
    clr = 1'b1;
    sel = c;
    repeat (8) @(negedge sys_clk);
    `CHK({stb, subst, viol, err, ready}, 5'h01)
    clr = 1'b0;
    repeat (16) @(negedge sys_clk);
    i_bzs_line_partner.rx_q = {};
    n_sub = 0;
    n_vio = 0;
    n_err = 0;
    n_one = 0;
  endtask
  // First eight bits pile up while stalled, keeping the line gapless
  task automatic push_bits();
    int w;
    foreach (bits[i])
    begin
      @(negedge sys_clk);
      hold = (i < 8);
      din = bits[i];
      dval = 1'b1;
      for (w = 0; ready !== 1'b1 && w < 99; w++)
        @(negedge sys_clk);
      if (w == 99)
      begin
        n_fail++;
        end_of_test();
      end
    end
    @(negedge sys_clk);
    dval = 1'b0;
  endtask
  task automatic run_code(input logic [1:0] c);
    string s = "100000000110000001000011100000000000010001000001";
    int ones, n;
    set_mode(c);
    bits = {};
    ones = 0;
    foreach (s[k])
    begin
      bits.push_back(s[k] == "1");
      ones += (s[k] == "1");
    end
    ref_code(c);
    n = exp_q.size();
    while (bits.size() < n)
      bits.push_back(1'b1);
    push_bits();
    repeat (40) @(negedge sys_clk);
    `CHK(i_bzs_line_partner.rx_q.size(), n)
    foreach (exp_q[k]) `CHK(i_bzs_line_partner.rx_q[k], exp_q[k])
    `CHK(n_sub, exp_sub)
    `CHK(n_vio, 0)
    `CHK(n_one, ones)
    $display("run_code %0d done", c);
  endtask
  task automatic t_decode();
    set_mode(2'h0);
    loop = 1'b0;
    @(posedge sys_clk);
    i_bzs_line_partner.tx_q = {SYM_PLUS, SYM_ZERO, SYM_PLUS, SYM_ZERO, SYM_MINUS, 2'h3, SYM_ZERO};
    repeat (30) @(negedge sys_clk);
    `CHK(n_vio, 1)
    `CHK(n_err, 1)
    loop = 1'b1;
    $display("t_decode done");
  endtask
  task automatic t_fifo();
    int n;
    set_mode(2'h1);
    hold = 1'b1;
    din = 1'b1;
    dval = 1'b1;
    for (n = 0; ready === 1'b1 && n < 40; n++)
      @(negedge sys_clk);
    `CHK(n, 16)
    repeat (3) @(negedge sys_clk);
    dval = 1'b0;
    // Enable low must freeze the full buffer and the encoder
    cen = 1'b0;
    hold = 1'b0;
    repeat (10) @(negedge sys_clk);
    `CHK(i_bzs_line_partner.rx_q.size(), 0)
    `CHK(ready, 1'b0)
    cen = 1'b1;
    repeat (40) @(negedge sys_clk);
    `CHK(i_bzs_line_partner.rx_q.size(), 16)
    `CHK(ready, 1'b1)
    $display("t_fifo done");
  endtask
  // Reset with bits parked in the buffer
  task automatic t_reset();
    hold = 1'b1;
    dval = 1'b1;
    din = 1'b0;
    repeat (5) @(negedge sys_clk);
    dval = 1'b0;
    rstn = 1'b0;
    // Forget symbols left from the buffer test
    i_bzs_line_partner.rx_q = {};
    repeat (4) @(negedge sys_clk);
    `CHK({stb, pos_o, neg_o, nrz_o, subst, viol, err, ready}, 8'h01)
    rstn = 1'b1;
    hold = 1'b0;
    repeat (20) @(negedge sys_clk);
    `CHK(i_bzs_line_partner.rx_q.size(), 0)
    $display("t_reset done");
  endtask
  initial
  begin
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    for (int c = 0; c < 4; c++)
      run_code(2'(c));
    t_decode();
    t_fifo();
    t_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
